// >>> inc/swk_mode_pkg.sv
/*
  Constants and types for the selective-wake mode control block.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
`default_nettype none
package swk_mode_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Control register fields
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB_BIT  = 2;
  localparam int CFG_VALID_BIT = 3;
  localparam int WAKE_SYSTEM_ERROR_FLAG_MASK_BIT = 4;

  // Status register fields
  localparam int SYNC_BIT      = 0;
  localparam int ARMED_BIT     = 1;
  localparam int WAKE_SYSTEM_ERROR_FLAG_BIT    = 2;
  localparam int SILENCE_BIT   = 3;
  localparam int WOKEN_BIT     = 4;
  localparam int SWK_ON_BIT    = 5;
  localparam int STATE_LSB     = 8;

  // Reset values
  localparam logic [2:0] MODE_RESET = 3'h0;

  // Transceiver mode codes
  localparam logic [2:0] MODE_OFF0      = 3'h0;
  localparam logic [2:0] MODE_WAKE      = 3'h1;
  localparam logic [2:0] MODE_RX_ONLY   = 3'h2;
  localparam logic [2:0] MODE_NORMAL    = 3'h3;
  localparam logic [2:0] MODE_OFF1      = 3'h4;
  localparam logic [2:0] MODE_SWK       = 3'h5;
  localparam logic [2:0] MODE_RX_SWK    = 3'h6;
  localparam logic [2:0] MODE_NORMAL_SWK = 3'h7;

  // Device power modes
  localparam logic [1:0] DEV_NORMAL = 2'h0;
  localparam logic [1:0] DEV_STOP   = 2'h1;
  localparam logic [1:0] DEV_SLEEP  = 2'h2;

  typedef enum logic [2:0] {
    SW_IDLE,
    SW_FRAME,
    SW_PAT1,
    SW_PAT2,
    SW_WOKEN
  } swk_state_type;

endpackage
`default_nettype wire

// >>> design/can_selective_wake_mode_control.sv
/*
  Mode and status control of the selective-wake function of a CAN transceiver,
  with a classic Wishbone register slave. Frame decoding, the protocol error
  counter and the silence timer live outside and report single-cycle events.
*/
`timescale 1ns/1ns
`default_nettype none
module can_selective_wake_mode_control (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Device power mode and bus events
  input  wire logic [1:0]  dev_mode_i,
  input  wire logic        frame_ok_i,
  input  wire logic        proto_err_i,
  input  wire logic        wake_frame_i,
  input  wire logic        wake_pattern_i,
  input  wire logic        count_overflow_i,
  input  wire logic        bus_idle_i,
  // Transceiver control
  output logic             rxd_data_en_o,
  output logic             txd_en_o,
  output logic             swk_monitor_o,
  output logic             rxd_wake_low_o,
  output logic             can_wake_irq_o,
  output logic             wake_system_error_flag_irq_o
);

  typedef struct packed {
    logic [2:0]                  mode;
    logic                        cfg_valid;
    logic                        wake_system_error_flag_mask;
    logic                        sync;
    logic                        armed;
    logic                        wake_system_error_flag;
    logic                        silence;
    logic                        woken;
    logic                        wake_irq;
    logic                        err_irq;
    logic                        rxd_low;
    swk_mode_pkg::swk_state_type st;
    logic [1:0]                  dev_mode;
    logic                        ack;
    logic [31:0]                 rdata;
  } state_type;

  state_type cur_ff;
  state_type nxt_ff;

  function automatic logic in_wait(input swk_mode_pkg::swk_state_type s);
    in_wait = (s == swk_mode_pkg::SW_FRAME) || (s == swk_mode_pkg::SW_PAT1) || (s == swk_mode_pkg::SW_PAT2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the stored mode

  logic       msb;
  logic [1:0] low;
  logic       swk_on;
  logic       listen;
  logic       bus_req;
  logic       wr_ctrl;
  logic       wr_status;
  logic       wake_hit;
  logic       err_set;

  assign msb     = cur_ff.mode[swk_mode_pkg::MODE_MSB_BIT];
  assign low     = cur_ff.mode[1:0];
  // Selective wake only with a valid code and no system error
  assign swk_on  = msb && (low != 2'h0) && !cur_ff.wake_system_error_flag;
  assign listen  = low[1] || (cur_ff.st == swk_mode_pkg::SW_FRAME);
  assign bus_req = cyc_i && stb_i && !cur_ff.ack;
  assign wr_ctrl   = bus_req && we_i && sel_i[0] && (adr_i == swk_mode_pkg::CTRL_OFFSET);
  assign wr_status = bus_req && we_i && sel_i[0] && (adr_i == swk_mode_pkg::STATUS_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [2:0] new_mode;
    logic       new_valid;
    logic       cfg_err;
    logic       mode_wr;
    new_mode  = cur_ff.mode;
    new_valid = cur_ff.cfg_valid;
    cfg_err   = 1'b0;
    mode_wr   = 1'b0;
    nxt_ff    = cur_ff;
    nxt_ff.wake_irq = 1'b0;
    nxt_ff.err_irq  = 1'b0;
    // Power mode is only tracked, never a gate on entry
    nxt_ff.dev_mode = dev_mode_i;

    // Bus slave, one wait state
    nxt_ff.ack = bus_req;
    if (bus_req && !we_i) begin
      case (adr_i)
        swk_mode_pkg::CTRL_OFFSET: nxt_ff.rdata = {27'h0, cur_ff.wake_system_error_flag_mask, cur_ff.cfg_valid, cur_ff.mode};
        swk_mode_pkg::STATUS_OFFSET: nxt_ff.rdata = {21'h0, cur_ff.st, 2'h0, swk_on, cur_ff.woken,
                                                     cur_ff.silence, cur_ff.wake_system_error_flag, cur_ff.armed, cur_ff.sync};
        default: nxt_ff.rdata = 32'h0;
      endcase
    end

    if (wr_ctrl) begin
      new_valid = dat_i[swk_mode_pkg::CFG_VALID_BIT];
      nxt_ff.wake_system_error_flag_mask = dat_i[swk_mode_pkg::WAKE_SYSTEM_ERROR_FLAG_MASK_BIT];
      // Mode is frozen outside Normal Mode
      if (dev_mode_i == swk_mode_pkg::DEV_NORMAL) begin
        new_mode = dat_i[2:0];
        mode_wr  = 1'b1;
      end
    end
    // Check on enabling wake, or losing validity while enabled
    if (new_mode[swk_mode_pkg::MODE_MSB_BIT] && (new_mode[1:0] != 2'h0) && !new_valid &&
        (mode_wr || cur_ff.cfg_valid)) begin
      cfg_err = 1'b1;
    end
    nxt_ff.mode      = new_mode;
    nxt_ff.cfg_valid = new_valid;

    // Wake events
    // No frame wake in the one cycle a system error still shows frame detection
    wake_hit = ((cur_ff.st == swk_mode_pkg::SW_FRAME) && !cur_ff.wake_system_error_flag && (wake_frame_i || count_overflow_i)) ||
               ((cur_ff.st == swk_mode_pkg::SW_PAT2) && wake_pattern_i);
    // Config check follows the code being written, not the one stored
    err_set  = cfg_err || (msb && count_overflow_i && in_wait(cur_ff.st));

    // Selective-wake state machine
    case (cur_ff.st)
      swk_mode_pkg::SW_IDLE: begin
        if (swk_on) begin
          nxt_ff.st = swk_mode_pkg::SW_FRAME;
        end else if (msb && cur_ff.wake_system_error_flag && !cur_ff.woken) begin
          nxt_ff.st = swk_mode_pkg::SW_PAT2;
        end
      end
      swk_mode_pkg::SW_FRAME: begin
        if (wake_hit) begin
          nxt_ff.st = swk_mode_pkg::SW_WOKEN;
        end else if (bus_idle_i) begin
          nxt_ff.st = swk_mode_pkg::SW_PAT1;
        end
      end
      swk_mode_pkg::SW_PAT1: begin
        if (wake_pattern_i) begin
          nxt_ff.st = swk_mode_pkg::SW_FRAME;
        end
      end
      swk_mode_pkg::SW_PAT2: begin
        if (wake_hit) begin
          nxt_ff.st = swk_mode_pkg::SW_WOKEN;
        end
      end
      swk_mode_pkg::SW_WOKEN: begin
        nxt_ff.st = swk_mode_pkg::SW_WOKEN;
      end
      default: begin
        nxt_ff.st = swk_mode_pkg::SW_IDLE;
      end
    endcase
    // A system error drops frame detection into pattern-2 waiting
    if (cur_ff.wake_system_error_flag && ((cur_ff.st == swk_mode_pkg::SW_FRAME) || (cur_ff.st == swk_mode_pkg::SW_PAT1))) begin
      nxt_ff.st = swk_mode_pkg::SW_PAT2;
    end
    // Rewriting the mode rearms; clearing the MSB leaves wake handling
    if (!msb || mode_wr) begin
      nxt_ff.st = swk_mode_pkg::SW_IDLE;
    end

    nxt_ff.armed = in_wait(nxt_ff.st);

    // Woken state, plain wake on pattern without selective wake
    if (mode_wr) begin
      nxt_ff.woken = 1'b0;
    end else if (wake_hit || (!msb && (low == 2'h1) && wake_pattern_i)) begin
      nxt_ff.woken = 1'b1;
    end
    // Wake frame in a data mode is an interrupt, not a pulled RXD
    if ((cur_ff.st == swk_mode_pkg::SW_FRAME) && !cur_ff.wake_system_error_flag && wake_frame_i) begin
      nxt_ff.wake_irq = 1'b1;
    end
    nxt_ff.rxd_low = nxt_ff.woken && !low[1];

    // Sync flag: a good frame beats a simultaneous error
    if (listen && frame_ok_i) begin
      nxt_ff.sync = 1'b1;
    end else if (proto_err_i) begin
      nxt_ff.sync = 1'b0;
    end

    // Silence flag while waiting for a frame or for pattern 2
    if (bus_idle_i && ((cur_ff.st == swk_mode_pkg::SW_FRAME) || (cur_ff.st == swk_mode_pkg::SW_PAT2))) begin
      nxt_ff.silence = 1'b1;
    end else if (wake_pattern_i) begin
      nxt_ff.silence = 1'b0;
    end

    // System error: set beats the software clear
    if (err_set) begin
      nxt_ff.wake_system_error_flag  = 1'b1;
      nxt_ff.err_irq = !cur_ff.wake_system_error_flag_mask;
    end else if (wr_status && dat_i[swk_mode_pkg::WAKE_SYSTEM_ERROR_FLAG_BIT] && !(msb && !new_valid)) begin
      nxt_ff.wake_system_error_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= '{mode: swk_mode_pkg::MODE_RESET, st: swk_mode_pkg::SW_IDLE, default: '0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; no gate on sync for power-mode entry

  assign dat_o          = cur_ff.rdata;
  assign ack_o          = cur_ff.ack;
  assign rxd_data_en_o  = low[1];
  assign txd_en_o       = (low == 2'h3);
  assign swk_monitor_o  = (cur_ff.st == swk_mode_pkg::SW_FRAME) || (cur_ff.st == swk_mode_pkg::SW_PAT1);
  assign rxd_wake_low_o = cur_ff.rxd_low;
  assign can_wake_irq_o = cur_ff.wake_irq;
  assign wake_system_error_flag_irq_o   = cur_ff.err_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_good_frame;
    listen && frame_ok_i;
  endsequence

  property p_sync_set;
    @(posedge clk_i) disable iff (rst_i) s_good_frame |=> cur_ff.sync;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync not set after good frame");

  property p_sync_clr;
    @(posedge clk_i) disable iff (rst_i) (proto_err_i && !(listen && frame_ok_i)) |=> !cur_ff.sync;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("sync kept after protocol error");

  property p_sync_only_listen;
    @(posedge clk_i) disable iff (rst_i) (!cur_ff.sync && !listen) |=> !cur_ff.sync;
  endproperty
  a_sync_only_listen: assert property (p_sync_only_listen) else $error("sync set while not listening");

  property p_mode_frozen;
    @(posedge clk_i) disable iff (rst_i) (dev_mode_i != swk_mode_pkg::DEV_NORMAL) |=> $stable(cur_ff.mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed outside Normal Mode");

  property p_msb_kept;
    @(posedge clk_i) disable iff (rst_i)
      (cur_ff.dev_mode == swk_mode_pkg::DEV_NORMAL && dev_mode_i != swk_mode_pkg::DEV_NORMAL) |=> $stable(msb);
  endproperty
  a_msb_kept: assert property (p_msb_kept) else $error("mode MSB altered on leaving Normal Mode");

  property p_tx_decode;
    @(posedge clk_i) disable iff (rst_i) txd_en_o == (cur_ff.mode == swk_mode_pkg::MODE_NORMAL ||
                                                      cur_ff.mode == swk_mode_pkg::MODE_NORMAL_SWK);
  endproperty
  a_tx_decode: assert property (p_tx_decode) else $error("transmit enable wrong for mode");

  sequence s_wake;
    cur_ff.st == swk_mode_pkg::SW_FRAME && wake_frame_i && msb && !cur_ff.wake_system_error_flag;
  endsequence

  property p_wake_clears_armed;
    @(posedge clk_i) disable iff (rst_i) s_wake |=> !cur_ff.armed && can_wake_irq_o;
  endproperty
  a_wake_clears_armed: assert property (p_wake_clears_armed) else $error("armed flag kept after wake");

  property p_armed_on_enable;
    @(posedge clk_i) disable iff (rst_i) (swk_on && cur_ff.st == swk_mode_pkg::SW_IDLE && !wr_ctrl) |=> cur_ff.armed;
  endproperty
  a_armed_on_enable: assert property (p_armed_on_enable) else $error("armed flag not set on enable");

  property p_err_irq;
    @(posedge clk_i) disable iff (rst_i) (!cur_ff.wake_system_error_flag ##1 cur_ff.wake_system_error_flag) |-> wake_system_error_flag_irq_o == !$past(cur_ff.wake_system_error_flag_mask);
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("system error interrupt mismatch");

  property p_no_wake_frame_on_err;
    @(posedge clk_i) disable iff (rst_i) cur_ff.wake_system_error_flag |-> ##1 (cur_ff.st != swk_mode_pkg::SW_FRAME);
  endproperty
  a_no_wake_frame_on_err: assert property (p_no_wake_frame_on_err) else $error("frame detection under system error");

endmodule // can_selective_wake_mode_control
`default_nettype wire

// >>> verification/can_bus_node.sv
/*
  Far-side CAN bus node model: turns a bench command into one event pulse.
  Assumes go_i is high for one clock cycle per event.
*/
`timescale 1ns/1ns
`default_nettype none
module can_bus_node (
  // Clock and command
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] kind_i,
  // Bus events towards the block
  output logic            frame_ok_o,
  output logic            proto_err_o,
  output logic            wake_frame_o,
  output logic            wake_pattern_o,
  output logic            count_overflow_o,
  output logic            bus_idle_o
);
  // Registered, so every event is a clean single-cycle pulse
  always_ff @(posedge clk_i) begin
    frame_ok_o       <= go_i && kind_i == 3'h0;
    proto_err_o      <= go_i && kind_i == 3'h1;
    wake_frame_o     <= go_i && kind_i == 3'h2;
    wake_pattern_o   <= go_i && kind_i == 3'h3;
    count_overflow_o <= go_i && kind_i == 3'h4;
    bus_idle_o       <= go_i && kind_i == 3'h5;
  end
endmodule // can_bus_node
`default_nettype wire

// >>> verification/tb_top.sv
/*
  Self-checking bench: Wishbone register calls and bus events with expected values.
  Assumes the design package and the bus node model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, go;
  logic [3:0] adr, sel;
  logic [31:0] dat, dat_o, rd;
  logic [1:0] dev_mode;
  logic [2:0] kind;
  logic ack_o, f_ok, p_err, w_fr, w_pat, c_ovf, b_idle;
  logic rxd_en, txd_en, mon, rxd_low, wake_irq, serr_irq;
  int error_cnt, n_tests, n_wake, n_serr, cyc_cnt;
  localparam logic [3:0] CT = swk_mode_pkg::CTRL_OFFSET;
  localparam logic [3:0] ST = swk_mode_pkg::STATUS_OFFSET;

  can_selective_wake_mode_control uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .dev_mode_i(dev_mode), .frame_ok_i(f_ok), .proto_err_i(p_err), .wake_frame_i(w_fr),
    .wake_pattern_i(w_pat), .count_overflow_i(c_ovf), .bus_idle_i(b_idle),
    .rxd_data_en_o(rxd_en), .txd_en_o(txd_en), .swk_monitor_o(mon), .rxd_wake_low_o(rxd_low),
    .can_wake_irq_o(wake_irq), .wake_system_error_flag_irq_o(serr_irq));
  can_bus_node node (.clk_i(clk_i), .go_i(go), .kind_i(kind), .frame_ok_o(f_ok),
    .proto_err_o(p_err), .wake_frame_o(w_fr), .wake_pattern_o(w_pat),
    .count_overflow_o(c_ovf), .bus_idle_o(b_idle));

  always #2 clk_i = ~clk_i;
  // Counted mid-cycle so a pulse is never raced at its own edge
  always @(negedge clk_i) begin
    if (wake_irq === 1'b1) n_wake++;
    if (serr_irq === 1'b1) n_serr++;
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic ev(input logic [2:0] k);
    @(posedge clk_i);
    {go, kind} <= {1'b1, k};
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk_i, cyc, stb, we, go, dev_mode, adr, dat, kind} = '0;
    rst_i = 1'b1;
    sel = 4'hF;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, CT, 0); chk("ctrl_reset", rd, 0);
    wb(0, ST, 0); chk("status_reset", rd, 0);
    wb(0, 4'h8, 0); chk("unmapped", rd, 0);
    ev(0); wb(0, ST, 0); chk("sync_off", rd[0], 0);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wb(1, CT, 32'h8 | c);
      wb(0, CT, 0); chk("mode_read", rd[2:0], c[2:0]);
      chk("rxd_en", rxd_en, c[1]);
      chk("txd_en", txd_en, c[1] & c[0]);
    end
    $display("test mode table done");
    wb(0, ST, 0); chk("armed", rd[1], 1);
    chk("swk_active", rd[5], 1);
    chk("state_frame", rd[10:8], 1);
    chk("monitor", mon, 1);
    ev(0); wb(0, ST, 0); chk("sync_set", rd[0], 1);
    ev(1); wb(0, ST, 0); chk("sync_clr", rd[0], 0);
    ev(5); wb(0, ST, 0); chk("silence", rd[3], 1);
    $display("test sync done");
    dev_mode <= 2'h1;
    wb(1, CT, 32'h8);
    wb(0, CT, 0); chk("mode_kept", rd[2:0], 7);
    chk("rx_stop", rxd_en, 1);
    chk("tx_stop", txd_en, 1);
    dev_mode <= 2'h0;
    $display("test stop done");
    // Silence left pattern-1 waiting; a pattern brings frame detection back
    ev(3); ev(2); wb(0, ST, 0); chk("armed_clr", rd[1], 0);
    chk("silence_clr", rd[3], 0);
    chk("woken", rd[4], 1);
    chk("rxd_low7", rxd_low, 0);
    chk("wake_irq", n_wake, 1);
    wb(1, CT, 32'hD); ev(2); wb(0, ST, 0);
    chk("rxd_low5", rxd_low, 1);
    chk("wake_irq5", n_wake, 2);
    $display("test wake done");
    // Config error: wake code written from a plain mode without the valid bit
    wb(1, CT, 32'h3); wb(1, CT, 32'h7); repeat (2) @(posedge clk_i); wb(0, ST, 0);
    chk("wake_system_error_flag", rd[2], 1);
    chk("armed_pat2", rd[1], 1);
    chk("swk_inactive", rd[5], 0);
    chk("state_pat2", rd[10:8], 3);
    chk("serr_irq", n_serr, 1);
    chk("no_monitor", mon, 0);
    ev(2); wb(0, CT, 0); chk("no_wake", n_wake, 2);
    chk("msb_kept", rd[2], 1);
    wb(1, ST, 32'h4); wb(0, ST, 0); chk("clr_refused", rd[2], 1);
    wb(1, CT, 32'hF); wb(1, ST, 32'h4); wb(0, ST, 0);
    chk("clr_done", rd[2], 0);
    // Interrupt masked first, then the valid bit dropped under a wake code
    wb(1, CT, 32'h1F); wb(1, CT, 32'h17); repeat (2) @(posedge clk_i); wb(0, ST, 0);
    chk("syserr2", rd[2], 1);
    chk("irq_masked", n_serr, 1);
    wb(1, CT, 32'hB); wb(0, ST, 0); chk("armed_msb", rd[1], 0);
    // Overflow in frame detection wakes and raises the system error
    wb(1, ST, 32'h4); wb(1, CT, 32'hF); ev(4); wb(0, ST, 0);
    chk("ovf_wake_system_error_flag", rd[2], 1);
    chk("ovf_armed", rd[1], 0);
    chk("ovf_woken", rd[4], 1);
    chk("ovf_irq", n_serr, 2);
    $display("test system error done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
